// *** hw/gcsc_top.sv ***
// Decided for this implementation: the register addresses and register access over AXI4-Lite.
`timescale 1ns/10ps
// How it works
// - Both pins of a pair reach networks.
// - Unused clock pins work as plain I/O.
// - Pins and dual pins route by fixed table.
// - Pin count set by number of sides.
// - Five blocks per side, one net each.
// - Each block takes exactly six candidate inputs.
// - Five pll outputs, two per block.
// - Pins and pll outputs selectable at run time.
// - Logic input chosen only by static mode.
// - No run-time select for dual or logic.
// - Only the side's own pll is selectable.
// - Static settings locked once in user mode.
// - User logic enables or disables each net.
// - Reference mux switched statically or by switchover.
// - Net feeds pll only from pin or pll.
// - Logic driven blocks never reach plls.
// - Plain I/O never reaches pll reference.
// - Logic may drive nets with any signal.
// - Enable sampled at source falling edge.
module gcsc_top
    import gcsc_pkg::*;
#(
    parameter int NUM_SIDES = GCSC_MAX_SIDES,
    parameter int NP        = NUM_SIDES * GCSC_PINS_PER_SIDE,
    parameter int NN        = NUM_SIDES * GCSC_NETS_PER_SIDE
) (
    // Clock and reset.
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    // AXI4-Lite write channels.
    input  wire logic [GCSC_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    // AXI4-Lite read channels.
    input  wire logic [GCSC_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    // Device state.
    input  wire logic                   user_mode,
    // Clock pins, pair k at 2k (positive) and 2k+1.
    input  wire logic [NP-1:0]          clk_pin_i,
    output logic      [NP-1:0]          clk_pin_o,
    output logic      [NP-1:0]          clk_pin_oe,
    // Dual purpose pins and pll counters.
    input  wire logic [GCSC_DP_PINS-1:0] dual_purpose_clock_pin,
    input  wire logic [NUM_SIDES*GCSC_PLL_OUTS-1:0] pll_clk_i,
    // User logic controls, one entry per network; pll switchover one per side.
    input  wire logic [NN-1:0]          internal_clk_i,
    input  wire logic [2*NN-1:0]        clk_select_i,
    input  wire logic [NN-1:0]          clk_enable_i,
    input  wire logic [NUM_SIDES-1:0]   pll_switch_i,
    // Networks and pll references.
    output logic      [NN-1:0]          global_clock_net,
    output logic      [NUM_SIDES-1:0]   pll_ref_clk_o
);
    typedef struct packed {
        logic                   aw_got;
        logic [GCSC_ADDR_W-1:0] awaddr;
        logic                   w_got;
        logic [31:0]            wdata;
        logic [3:0]             wstrb;
        logic                   bvalid;
        logic [1:0]             bresp;
        logic                   rvalid;
        logic [31:0]            rdata;
        logic [1:0]             rresp;
        logic [31:0]            mode_lo;
        logic [7:0]             mode_hi;
        logic [31:0]            ref_cfg;
        logic [15:0]            gpio_en;
        logic [15:0]            pin_out;
        logic [3:0]             ref_q;
    } gcsc_top_t;

    gcsc_top_t st;
    gcsc_top_t next_st;

    logic [NP-1:0]                   pin_sync;
    logic [GCSC_DP_PINS-1:0]         dp_sync;
    logic [NUM_SIDES*GCSC_PLL_OUTS-1:0] pll_sync;
    logic [NN-1:0]                   net_w;
    logic [NN-1:0]                   active_w;
    logic [NN-1:0]                   pll_ok_w;
    logic [GCSC_MAX_PINS-1:0]        pin_full;
    logic [GCSC_MAX_PINS-1:0]        pin_clk_full;
    logic [31:0]                     net_full;
    logic [31:0]                     ok_full;
    logic [31:0]                     active_full;
    logic [GCSC_MAX_SIDES-1:0]       sw_full;
    logic [39:0]                     mode_all;

    // Pins and foreign clocks pass two flops first.
    gcsc_sync #(.WIDTH(NP)) u_pin_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .async_i (clk_pin_i),
        .sync_o  (pin_sync)
    );

    gcsc_sync #(.WIDTH(GCSC_DP_PINS)) u_dp_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .async_i (dual_purpose_clock_pin),
        .sync_o  (dp_sync)
    );

    gcsc_sync #(.WIDTH(NUM_SIDES*GCSC_PLL_OUTS)) u_pll_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .async_i (pll_clk_i),
        .sync_o  (pll_sync)
    );

    assign mode_all = {st.mode_hi, st.mode_lo};

    // Pad per-pin and per-net vectors to the register width.
    genvar gp;
    generate
        for (gp = 0; gp < 32; gp++) begin : g_pad
            if (gp < NP) begin : g_pin
                assign pin_full[gp]     = pin_sync[gp];
                // A pin in I/O use carries no clock anywhere.
                assign pin_clk_full[gp] = pin_sync[gp] & ~st.gpio_en[gp];
            end else if (gp < GCSC_MAX_PINS) begin : g_nopin
                assign pin_full[gp]     = 1'b0;
                assign pin_clk_full[gp] = 1'b0;
            end
            if (gp < NN) begin : g_net
                assign net_full[gp]    = net_w[gp];
                assign ok_full[gp]     = pll_ok_w[gp];
                assign active_full[gp] = active_w[gp];
            end else begin : g_nonet
                assign net_full[gp]    = 1'b0;
                assign ok_full[gp]     = 1'b0;
                assign active_full[gp] = 1'b0;
            end
            if (gp < NUM_SIDES) begin : g_side
                assign sw_full[gp] = pll_switch_i[gp];
            end else if (gp < GCSC_MAX_SIDES) begin : g_noside
                assign sw_full[gp] = 1'b0;
            end
        end
    endgenerate

    // One clock control block per global network, five per side.
    genvar gj;
    generate
        for (gj = 0; gj < NN; gj++) begin : g_ccb
            localparam int S  = gj / GCSC_NETS_PER_SIDE;
            localparam int L  = gj % GCSC_NETS_PER_SIDE;
            localparam int PA = S * GCSC_PINS_PER_SIDE +
                                int'(GCSC_NET_PIN_A[2*L +: 2]);
            localparam int PB = S * GCSC_PINS_PER_SIDE +
                                int'(GCSC_NET_PIN_B[2*L +: 2]);
            localparam int CA = S * GCSC_PLL_OUTS + L;
            localparam int CB = S * GCSC_PLL_OUTS + (L + 1) % GCSC_PLL_OUTS;
            localparam logic [2:0] DPE = GCSC_NET_DP[3*gj +: 3];
            logic [5:0] src;
            assign src[0] = pin_clk_full[PA];
            assign src[1] = pin_clk_full[PB];
            assign src[2] = pll_sync[CA];
            assign src[3] = pll_sync[CB];
            assign src[4] = DPE[2] ? dp_sync[DPE[1:0]] : 1'b0;
            assign src[5] = internal_clk_i[gj];
            gcsc_ccb u_ccb (
                .aclk      (aclk),
                .aresetn   (aresetn),
                .src_i     (src),
                .mode_i    (mode_all[2*gj +: 2]),
                .dyn_sel_i (clk_select_i[2*gj +: 2]),
                .enable_i  (clk_enable_i[gj]),
                .net_o     (net_w[gj]),
                .active_o  (active_w[gj]),
                .pll_ok_o  (pll_ok_w[gj])
            );
        end
    endgenerate

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0]  strb);
        merge = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                merge[8*b +: 8] = data[8*b +: 8];
            end
        end
    endfunction

    // Bus slave, pll reference muxes and register file.
    always_comb begin
        logic       aw_have;
        logic       w_have;
        logic [4:0] cn;
        logic       sw;
        logic [31:0] m;
        aw_have = 1'b0;
        w_have  = 1'b0;
        cn      = 5'h00;
        sw      = 1'b0;
        m       = 32'h0000_0000;
        next_st = st;
        if (s_axi_awvalid && s_axi_awready) begin
            next_st.aw_got = 1'b1;
            next_st.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_st.w_got = 1'b1;
            next_st.wdata = s_axi_wdata;
            next_st.wstrb = s_axi_wstrb;
        end
        aw_have = next_st.aw_got;
        w_have  = next_st.w_got;
        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end
        if (aw_have && w_have && !st.bvalid) begin
            next_st.aw_got = 1'b0;
            next_st.w_got  = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp  = GCSC_RESP_OKAY;
            m = merge(32'h0000_0000, next_st.wdata, next_st.wstrb);
            case (next_st.awaddr)
                GCSC_OFF_MODE_LO: begin
                    if (user_mode) begin
                        next_st.bresp = GCSC_RESP_SLVERR;
                    end else begin
                        next_st.mode_lo = merge(st.mode_lo, next_st.wdata,
                                                next_st.wstrb);
                    end
                end
                GCSC_OFF_MODE_HI: begin
                    if (user_mode) begin
                        next_st.bresp = GCSC_RESP_SLVERR;
                    end else if (next_st.wstrb[0]) begin
                        next_st.mode_hi = m[7:0];
                    end
                end
                GCSC_OFF_REF_CFG: begin
                    if (user_mode) begin
                        next_st.bresp = GCSC_RESP_SLVERR;
                    end else begin
                        next_st.ref_cfg = merge(st.ref_cfg, next_st.wdata,
                                                next_st.wstrb);
                    end
                end
                GCSC_OFF_GPIO_EN: begin
                    m = merge({16'h0000, st.gpio_en}, next_st.wdata,
                              next_st.wstrb);
                    next_st.gpio_en = m[15:0];
                end
                GCSC_OFF_PIN_OUT: begin
                    m = merge({16'h0000, st.pin_out}, next_st.wdata,
                              next_st.wstrb);
                    next_st.pin_out = m[15:0];
                end
                default: begin
                    next_st.bresp = GCSC_RESP_SLVERR;
                end
            endcase
        end
        if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_st.rvalid = 1'b1;
            next_st.rresp  = GCSC_RESP_OKAY;
            case (s_axi_araddr)
                GCSC_OFF_MODE_LO: next_st.rdata = st.mode_lo;
                GCSC_OFF_MODE_HI: next_st.rdata = {24'h000000, st.mode_hi};
                GCSC_OFF_REF_CFG: next_st.rdata = st.ref_cfg;
                GCSC_OFF_GPIO_EN: next_st.rdata = {16'h0000, st.gpio_en};
                GCSC_OFF_PIN_OUT: next_st.rdata = {16'h0000, st.pin_out};
                GCSC_OFF_PIN_IN:  next_st.rdata = {16'h0000, pin_full};
                GCSC_OFF_ACTIVE:  next_st.rdata = active_full;
                default: begin
                    next_st.rdata = 32'h0000_0000;
                    next_st.rresp = GCSC_RESP_SLVERR;
                end
            endcase
        end
        // A cascaded net is used only if its block runs from a pin or pll;
        // other sources are gated off.
        for (int s = 0; s < GCSC_MAX_SIDES; s++) begin
            cn = st.ref_cfg[GCSC_REF_BYTE*s + GCSC_REF_NET_LSB +: 5];
            sw = st.ref_cfg[GCSC_REF_BYTE*s + GCSC_REF_SW_BIT] | sw_full[s];
            if (sw) begin
                next_st.ref_q[s] = net_full[cn] & ok_full[cn];
            end else begin
                next_st.ref_q[s] = pin_clk_full[{2'(s),
                    st.ref_cfg[GCSC_REF_BYTE*s + GCSC_REF_PIN_LSB +: 2]}];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st         <= '0;
            st.mode_lo <= GCSC_RST_MODE_LO;
            st.mode_hi <= GCSC_RST_MODE_HI;
            st.ref_cfg <= GCSC_RST_REF_CFG;
            st.gpio_en <= GCSC_RST_GPIO_EN;
            st.pin_out <= GCSC_RST_PIN_OUT;
        end else begin
            st <= next_st;
        end
    end

    // Handshake outputs; a new request waits while an answer stands.
    assign s_axi_awready    = !st.aw_got && !st.bvalid;
    assign s_axi_wready     = !st.w_got && !st.bvalid;
    assign s_axi_bvalid     = st.bvalid;
    assign s_axi_bresp      = st.bresp;
    assign s_axi_arready    = !st.rvalid;
    assign s_axi_rvalid     = st.rvalid;
    assign s_axi_rdata      = st.rdata;
    assign s_axi_rresp      = st.rresp;
    assign clk_pin_o        = st.pin_out[NP-1:0];
    assign clk_pin_oe       = st.gpio_en[NP-1:0];
    assign global_clock_net = net_w;
    assign pll_ref_clk_o    = st.ref_q[NUM_SIDES-1:0];
endmodule

// *** hw/gcsc_pkg.sv ***
package gcsc_pkg;

    // Device geometry.
    localparam int GCSC_MAX_SIDES      = 4;
    localparam int GCSC_NETS_PER_SIDE  = 5;
    localparam int GCSC_PINS_PER_SIDE  = 4;
    localparam int GCSC_DP_PINS        = 4;
    localparam int GCSC_PLL_OUTS       = 5;
    localparam int GCSC_MAX_PINS       = GCSC_MAX_SIDES * GCSC_PINS_PER_SIDE;

    // Register bus.
    localparam int         GCSC_ADDR_W      = 8;
    localparam logic [7:0] GCSC_OFF_MODE_LO = 8'h00;
    localparam logic [7:0] GCSC_OFF_MODE_HI = 8'h04;
    localparam logic [7:0] GCSC_OFF_REF_CFG = 8'h08;
    localparam logic [7:0] GCSC_OFF_GPIO_EN = 8'h0C;
    localparam logic [7:0] GCSC_OFF_PIN_OUT = 8'h10;
    localparam logic [7:0] GCSC_OFF_PIN_IN  = 8'h14;
    localparam logic [7:0] GCSC_OFF_ACTIVE  = 8'h18;
    localparam logic [1:0] GCSC_RESP_OKAY   = 2'h0;
    localparam logic [1:0] GCSC_RESP_SLVERR = 2'h2;

    // Reset values.
    localparam logic [31:0] GCSC_RST_MODE_LO = 32'h0000_0000;
    localparam logic [7:0]  GCSC_RST_MODE_HI = 8'h00;
    localparam logic [31:0] GCSC_RST_REF_CFG = 32'h0000_0000;
    localparam logic [15:0] GCSC_RST_GPIO_EN = 16'h0000;
    localparam logic [15:0] GCSC_RST_PIN_OUT = 16'h0000;

    // Reference configuration field layout, one byte per side.
    localparam int GCSC_REF_PIN_LSB  = 0;
    localparam int GCSC_REF_SW_BIT   = 2;
    localparam int GCSC_REF_NET_LSB  = 3;
    localparam int GCSC_REF_BYTE     = 8;

    // Static source mode of one clock control block.
    typedef enum logic [1:0] {
        GCSC_MODE_DYN  = 2'h0,
        GCSC_MODE_DP   = 2'h1,
        GCSC_MODE_INT  = 2'h2,
        GCSC_MODE_OFF  = 2'h3
    } gcsc_mode_t;

    // Current source codes inside a block; 0 to 3 follow the select lines.
    localparam logic [2:0] GCSC_SEL_DP  = 3'h4;
    localparam logic [2:0] GCSC_SEL_INT = 3'h5;
    localparam logic [2:0] GCSC_SEL_OFF = 3'h6;

    // Pin pair to network routing, per local net, pins p0 n0 p1 n1 = 0..3.
    localparam logic [9:0] GCSC_NET_PIN_A = {2'h0, 2'h2, 2'h0, 2'h1, 2'h0};
    localparam logic [9:0] GCSC_NET_PIN_B = {2'h2, 2'h3, 2'h1, 2'h2, 2'h3};

    // Dual purpose pin per global net: valid bit then pin index.
    localparam logic [59:0] GCSC_NET_DP = {{10{3'h0}},
        3'h7, 3'h7, 3'h6, 3'h7, 3'h6, 3'h5, 3'h5, 3'h5, 3'h4, 3'h4};

endpackage

// *** hw/gcsc_sync.sv ***
`timescale 1ns/10ps
module gcsc_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset.
    input  wire logic             aclk,
    input  wire logic             aresetn,
    // Levels.
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
    } gcsc_sync_t;

    gcsc_sync_t st;
    gcsc_sync_t next_st;

    // The first stage feeds only the second stage.
    always_comb begin
        next_st      = st;
        next_st.meta = async_i;
        next_st.sync = st.meta;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign sync_o = st.sync;
endmodule

// *** hw/gcsc_ccb.sv ***
`timescale 1ns/10ps
module gcsc_ccb
    import gcsc_pkg::*;
(
    // Clock and reset.
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // Candidate sources: pin a, pin b, pll a, pll b, dual purpose, logic.
    input  wire logic [5:0] src_i,
    // Static configuration and user controls.
    input  wire logic [1:0] mode_i,
    input  wire logic [1:0] dyn_sel_i,
    input  wire logic       enable_i,
    // Network and status.
    output logic            net_o,
    output logic            active_o,
    output logic            pll_ok_o
);
    typedef enum logic [1:0] {
        GCSC_RUN  = 2'h0,
        GCSC_PARK = 2'h1
    } gcsc_ccb_state_t;

    typedef struct packed {
        gcsc_ccb_state_t state;
        logic [2:0]      cur_sel;
        logic            prev;
        logic            en;
        logic            out;
    } gcsc_ccb_t;

    gcsc_ccb_t st;
    gcsc_ccb_t next_st;
    logic [2:0] want_sel;
    logic       cur_v;

    function automatic logic src_val(input logic [5:0] s,
                                     input logic [2:0] k);
        src_val = (k < GCSC_SEL_OFF) ? s[k] : 1'b0;
    endfunction

    // Only dedicated pins and pll outputs follow the select lines.
    always_comb begin
        case (mode_i)
            GCSC_MODE_DYN: want_sel = {1'b0, dyn_sel_i};
            GCSC_MODE_DP:  want_sel = GCSC_SEL_DP;
            GCSC_MODE_INT: want_sel = GCSC_SEL_INT;
            default:       want_sel = GCSC_SEL_OFF;
        endcase
    end

    // Sources switch only while low, so no runt; costs dead low time.
    always_comb begin
        next_st      = st;
        cur_v        = src_val(src_i, st.cur_sel);
        next_st.prev = cur_v;
        if ((st.prev && !cur_v) || (st.cur_sel == GCSC_SEL_OFF)) begin
            next_st.en = enable_i;
        end
        case (st.state)
            GCSC_RUN: begin
                if ((want_sel != st.cur_sel) && !cur_v) begin
                    next_st.state = GCSC_PARK;
                end
            end
            GCSC_PARK: begin
                if (!src_val(src_i, want_sel)) begin
                    next_st.cur_sel = want_sel;
                    next_st.state   = GCSC_RUN;
                    next_st.prev    = 1'b0;
                end
            end
            default: begin
                next_st.state = GCSC_RUN;
            end
        endcase
        next_st.out = (next_st.state == GCSC_RUN) && next_st.en &&
                      src_val(src_i, next_st.cur_sel);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '{GCSC_RUN, GCSC_SEL_OFF, 1'b0, 1'b0, 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign net_o    = st.out;
    assign active_o = (st.state == GCSC_RUN) && st.en &&
                      (st.cur_sel != GCSC_SEL_OFF);
    // Only pin or pll driven blocks may cascade into a pll.
    assign pll_ok_o = (st.state == GCSC_RUN) && (st.cur_sel < GCSC_SEL_DP);
endmodule

// *** verif/gcsc_chk.sv ***
`timescale 1ns/10ps
module gcsc_chk #(
    parameter int NN = 20
) (
    // Clock and reset.
    input wire logic          aclk,
    input wire logic          aresetn,
    // Register bus.
    input wire logic          s_axi_awvalid,
    input wire logic          s_axi_awready,
    input wire logic          s_axi_wvalid,
    input wire logic          s_axi_wready,
    input wire logic [1:0]    s_axi_bresp,
    input wire logic          s_axi_bvalid,
    input wire logic          s_axi_bready,
    input wire logic          s_axi_arvalid,
    input wire logic          s_axi_arready,
    input wire logic [31:0]   s_axi_rdata,
    input wire logic          s_axi_rvalid,
    input wire logic          s_axi_rready,
    // Networks.
    input wire logic [NN-1:0] clk_enable_i,
    input wire logic [NN-1:0] global_clock_net
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [5:0] off_cnt;
    // Cycles since net 0 was last enabled, held at the top.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            off_cnt <= 6'h00;
        end else if (clk_enable_i[0]) begin
            off_cnt <= 6'h00;
        end else if (off_cnt != 6'h3F) begin
            off_cnt <= off_cnt + 6'h01;
        end
    end
    bresp_hold_a: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("bresp not held");
    rdata_hold_a: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("rdata not held");
    write_block_a: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken early");
    read_block_a: assert property (
        s_axi_rvalid |-> !s_axi_arready) else $error("read taken early");
    write_answer_a: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> s_axi_bvalid) else $error("bvalid late");
    read_answer_a: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("rvalid late");
    // A one-cycle high pulse shows as 0, 1, 0 over three samples.
    no_runt_a: assert property (
        !(|(~$past(global_clock_net, 2) & $past(global_clock_net) &
            ~global_clock_net))) else $error("runt pulse");
    disabled_low_a: assert property (
        off_cnt == 6'h3F |-> !global_clock_net[0])
        else $error("net not low");
    cover property (s_axi_bvalid && s_axi_bready);
    cover property (s_axi_rvalid && s_axi_rready);
    cover property (off_cnt == 6'h3F);
endmodule

// *** verif/gcsc_src_model.sv ***
`timescale 1ns/10ps
// Free-running sources; distinct periods tell them apart by edge count.
module gcsc_src_model (
    // Clock.
    input  wire logic        aclk,
    // Sources.
    output logic      [15:0] pin_o,
    output logic      [19:0] pll_o,
    output logic      [3:0]  dp_o,
    output logic      [19:0] int_o
);
    int t = 0;
    // Time base; all half periods stay at two cycles or more.
    always @(posedge aclk) t <= t + 1;
    // Both pins of a pair run as separate single-ended clocks.
    always_comb begin
        for (int i = 0; i < 16; i++)
            pin_o[i] = 1'((t / (2 + i % 4)) % 2);
        for (int i = 0; i < 20; i++)
            pll_o[i] = 1'((t / (3 + i % 5)) % 2);
        dp_o  = {4{1'((t / 7) % 2)}};
        int_o = {20{1'((t / 6) % 2)}};
    end
endmodule

// *** verif/global_clock_source_control_tb.sv ***
`timescale 1ns/10ps
module global_clock_source_control_tb
    import gcsc_pkg::*;
;
    logic        aclk = 1'h0, aresetn = 1'h0, user_mode = 1'h0;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic        s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    logic [3:0]  s_axi_wstrb = 4'hF, pll_switch_i = 4'h0, pll_ref_clk_o;
    logic [3:0]  dual_purpose_clock_pin;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d, m;
    logic [15:0] clk_pin_i, clk_pin_o, clk_pin_oe;
    logic [19:0] pll_clk_i, internal_clk_i, global_clock_net;
    logic [19:0] clk_enable_i = 20'h0;
    logic [39:0] clk_select_i = 40'h0;
    int          failures = 0, comparisons = 0, n, r;

    always #5 aclk = ~aclk;
    gcsc_top #(.NUM_SIDES(4)) i_gcsc_top (.*);
    gcsc_src_model i_gcsc_src_model (.aclk(aclk), .pin_o(clk_pin_i),
        .pll_o(pll_clk_i), .dp_o(dual_purpose_clock_pin),
        .int_o(internal_clk_i));

    task automatic chk(input string w, input logic [31:0] s, e);
        comparisons++;
        if (s !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", w, e, s);
        end
    endtask
    // Response ready is raised late on purpose to exercise the hold path.
    task automatic wr(input logic [7:0] a, input logic [31:0] v,
                      output logic [1:0] rsp);
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata} <= {a, v};
        {s_axi_awvalid, s_axi_wvalid} <= 2'h3;
        forever begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid && s_axi_bready) begin
                rsp = s_axi_bresp;
                s_axi_bready <= 1'h0;
                break;
            end
            if (s_axi_bvalid) s_axi_bready <= 1'h1;
        end
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v,
                      output logic [1:0] rsp);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        forever begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid && s_axi_rready) begin
                {v, rsp} = {s_axi_rdata, s_axi_rresp};
                s_axi_rready <= 1'h0;
                break;
            end
            if (s_axi_rvalid) s_axi_rready <= 1'h1;
        end
    endtask
    // Counts rising edges over 840 cycles, a whole number of every period.
    task automatic meas(output int nc, rc);
        logic [1:0] p;
        {nc, rc} = '0;
        repeat (40) @(posedge aclk);
        p = {global_clock_net[0], pll_ref_clk_o[0]};
        repeat (840) begin
            @(posedge aclk);
            nc += int'(global_clock_net[0] && !p[1]);
            rc += int'(pll_ref_clk_o[0] && !p[0]);
            p = {global_clock_net[0], pll_ref_clk_o[0]};
        end
    endtask
    function automatic int edges(int h);
        return h ? 420 / h : 0;
    endfunction
    task automatic finish_test;
        $display("Comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        logic [7:0] ad[6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h1C};
        int         h[8] = '{2, 5, 3, 4, 7, 6, 0, 0};
        void'($urandom(51697));
        clk_select_i <= 40'({$urandom, $urandom});
        clk_enable_i <= 20'($urandom) | 20'h1;
        repeat (10) @(posedge aclk);
        aresetn <= 1'h1;
        foreach (ad[i]) begin
            rd(ad[i], d, rs);
            chk("reset value", d, 32'h0);
            chk("read resp", 32'(rs), i == 5 ? 32'h2 : 32'h0);
        end
        $display("Test reset values done");
        m = $urandom;
        wr(8'h0C, {16'h0, m[15:0]}, rs);
        wr(8'h10, {16'h0, m[31:16]}, rs);
        chk("pin enable", 32'(clk_pin_oe), 32'(m[15:0]));
        chk("pin out", 32'(clk_pin_o), 32'(m[31:16]));
        wr(8'h14, m, rs);
        chk("read only write", 32'(rs), 32'(GCSC_RESP_SLVERR));
        wr(8'h0C, 32'h0, rs);
        $display("Test pin io done");
        pll_switch_i <= 4'h1;
        for (int k = 0; k < 8; k++) begin
            m = $urandom;
            wr(8'h00, {m[31:2], (k < 4 || k == 7) ? 2'h0 : 2'(k - 3)}, rs);
            clk_select_i[1:0] <= k < 4 ? 2'(k) : 2'($urandom);
            clk_enable_i[0] <= (k != 7);
            meas(n, r);
            chk("net edges", n, edges(h[k]));
            chk("ref edges", r, k < 4 ? edges(h[k]) : 0);
        end
        $display("Test source select done");
        pll_switch_i <= 4'h0;
        for (int g = 0; g < 2; g++) begin
            wr(8'h0C, 32'(g), rs);
            meas(n, r);
            chk("pin ref edges", r, g ? 0 : edges(2));
        end
        $display("Test reference done");
        user_mode <= 1'h1;
        for (int i = 0; i < 3; i++) begin
            rd(ad[i], d, rs);
            wr(ad[i], ~d, rs);
            chk("locked resp", 32'(rs), 32'(GCSC_RESP_SLVERR));
            rd(ad[i], m, rs);
            chk("locked value", m, d);
        end
        $display("Test lock done");
        finish_test;
    end
    // The tests need about 10000 cycles; twice that means a hang.
    initial begin
        repeat (20000) @(posedge aclk);
        failures++;
        finish_test;
    end
endmodule

bind gcsc_top gcsc_chk #(.NN(NN)) i_gcsc_chk (.*);
